/* File: iq_corr_pkg.sv */
package iq_corr_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_I_GAIN      = 8'h0c;
    localparam logic [7:0] IDX_Q_GAIN      = 8'h0d;
    localparam logic [7:0] IDX_RSVD_0E     = 8'h0e;
    localparam logic [7:0] IDX_OUT_LAT     = 8'h0f;
    localparam logic [7:0] IDX_PHASE       = 8'h10;
    localparam logic [7:0] IDX_SYNC_CTRL   = 8'h20;
    localparam logic [7:0] IDX_ACT_STATUS  = 8'h21;
    localparam logic [7:0] IDX_ACT_GAINS   = 8'h22;

    localparam logic [7:0] ADDR_I_GAIN     = {IDX_I_GAIN[5:0], 2'b00};
    localparam logic [7:0] ADDR_Q_GAIN     = {IDX_Q_GAIN[5:0], 2'b00};
    localparam logic [7:0] ADDR_RSVD_0E    = {IDX_RSVD_0E[5:0], 2'b00};
    localparam logic [7:0] ADDR_OUT_LAT    = {IDX_OUT_LAT[5:0], 2'b00};
    localparam logic [7:0] ADDR_PHASE      = {IDX_PHASE[5:0], 2'b00};
    localparam logic [7:0] ADDR_SYNC_CTRL  = {IDX_SYNC_CTRL[5:0], 2'b00};
    localparam logic [7:0] ADDR_ACT_STATUS = {IDX_ACT_STATUS[5:0], 2'b00};
    localparam logic [7:0] ADDR_ACT_GAINS  = {IDX_ACT_GAINS[5:0], 2'b00};

    // Reset values
    localparam logic [15:0] RST_GAIN       = 16'h0400;
    localparam logic [15:0] RST_RSVD_0E    = 16'h0400;
    localparam logic [15:0] RST_OUT_LAT    = 16'h0400;
    localparam logic [15:0] RST_PHASE      = 16'h0000;

    // Field layout
    localparam int          GAIN_W         = 11;
    localparam int          GAIN_FRAC      = 10;
    localparam int          PHASE_W        = 12;
    localparam int          PHASE_FRAC     = 12;
    localparam int          DLY_LSB        = 14;
    localparam int          DLY_W          = 2;
    localparam int          MAX_DLY        = 3;
    localparam logic [15:0] GAIN_WR_MASK   = 16'h07ff;
    localparam logic [15:0] PHASE_WR_MASK  = 16'h3fff;
    localparam logic [15:0] OUT_LAT_WR_MASK = 16'hc000;
    localparam int          SYNC_EN_BIT    = 0;
    localparam int          SYNC_TRIG_BIT  = 1;

    // AXI responses
    localparam logic [1:0]  RESP_OKAY      = 2'b00;
    localparam logic [1:0]  RESP_SLVERR    = 2'b10;
endpackage

/* File: iq_phase_corr_output_delay.sv */
`timescale 1ns/10ps
module iq_phase_corr_output_delay #(
    parameter int SAMPLE_W   = 16,
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic [2:0]            s_axi_awprot,
    input  wire logic                  s_axi_awvalid,
    output      logic                  s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output      logic                  s_axi_wready,
    output      logic [1:0]            s_axi_bresp,
    output      logic                  s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic [2:0]            s_axi_arprot,
    input  wire logic                  s_axi_arvalid,
    output      logic                  s_axi_arready,
    output      logic [31:0]           s_axi_rdata,
    output      logic [1:0]            s_axi_rresp,
    output      logic                  s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic                  ext_sync,
    input  wire logic                  in_valid,
    output      logic                  in_ready,
    input  wire logic [SAMPLE_W-1:0]   in_a,
    input  wire logic [SAMPLE_W-1:0]   in_b,
    output      logic                  out_valid,
    input  wire logic                  out_ready,
    output      logic [SAMPLE_W-1:0]   out_a,
    output      logic [SAMPLE_W-1:0]   out_b
);
    localparam int GW    = iq_corr_pkg::GAIN_W;
    localparam int PW    = iq_corr_pkg::PHASE_W;
    localparam int PROD_W = SAMPLE_W + GW + 1;
    localparam int SUM_W = SAMPLE_W + 3;
    localparam int LVL_W = $clog2(FIFO_DEPTH) + 1;

    // Write channel holding and read response registers
    logic            aw_held_reg;
    logic [7:0]      aw_addr_reg;
    logic            w_held_reg;
    logic [31:0]     w_data_reg;
    logic [3:0]      w_strb_reg;
    logic            bvalid_reg;
    logic [1:0]      bresp_reg;
    logic            rvalid_reg;
    logic [1:0]      rresp_reg;
    logic [31:0]     rdata_reg;

    // Configuration storage
    logic [15:0]     i_gain_register_reg;
    logic [15:0]     q_gain_register_reg;
    logic [15:0]     out_lat_reg;
    logic [15:0]     phase_correction_register_reg;
    logic            autosync_en_reg;
    logic [GW-1:0]   act_i_gain_reg;
    logic [GW-1:0]   act_q_gain_reg;
    logic [PW-1:0]   act_phase_reg;
    logic [7:0]      sync_count_reg;

    // External sync synchroniser
    logic            ext_sync_meta_reg;
    logic            ext_sync_sync_reg;
    logic            ext_sync_prev_reg;

    // Datapath
    logic [SAMPLE_W-1:0] a0_reg;
    logic [SAMPLE_W-1:0] b0_reg;
    logic                v0_reg;
    logic [SAMPLE_W-1:0] a_dly_reg [iq_corr_pkg::MAX_DLY];
    logic [SAMPLE_W-1:0] b_dly_reg [iq_corr_pkg::MAX_DLY];
    logic                v_dly_reg [iq_corr_pkg::MAX_DLY];

    // Decode wires
    wire             do_write  = aw_held_reg && w_held_reg && !bvalid_reg;
    wire  [7:0]      wa        = aw_addr_reg;
    wire             wr_igain  = do_write && (wa == iq_corr_pkg::ADDR_I_GAIN);
    wire             wr_qgain  = do_write && (wa == iq_corr_pkg::ADDR_Q_GAIN);
    wire             wr_rsvd   = do_write && (wa == iq_corr_pkg::ADDR_RSVD_0E);
    wire             wr_outlat = do_write && (wa == iq_corr_pkg::ADDR_OUT_LAT);
    wire             wr_phase  = do_write && (wa == iq_corr_pkg::ADDR_PHASE);
    wire             wr_sync   = do_write && (wa == iq_corr_pkg::ADDR_SYNC_CTRL);
    wire             wr_ro     = do_write && ((wa == iq_corr_pkg::ADDR_ACT_STATUS) ||
                                              (wa == iq_corr_pkg::ADDR_ACT_GAINS));
    wire             wr_hit    = wr_igain || wr_qgain || wr_rsvd || wr_outlat || wr_phase || wr_sync || wr_ro;
    wire  [15:0]     be_mask   = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
    wire  [15:0]     wd        = w_data_reg[15:0];
    wire             ar_take   = s_axi_arvalid && s_axi_arready;
    wire             ext_pulse = ext_sync_sync_reg && !ext_sync_prev_reg;
    wire             trig_wr   = wr_sync && w_strb_reg[0] && wd[iq_corr_pkg::SYNC_TRIG_BIT];
    wire             auto_sync = wr_phase && autosync_en_reg;
    wire             sync_evt  = auto_sync || trig_wr || ext_pulse;

    // Merge a write into a register under byte enables and a writable mask
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [15:0] be, input logic [15:0] wm);
        logic [15:0] m;
        m = be & wm;
        merge = (old & ~m) | (nw & m);
    endfunction

    // Staged values, as they would be after this cycle's write
    wire  [15:0] phase_next  = wr_phase ? merge(phase_correction_register_reg, wd, be_mask,
                                                iq_corr_pkg::PHASE_WR_MASK) : phase_correction_register_reg;
    wire  [15:0] igain_next  = wr_igain ? merge(i_gain_register_reg, wd, be_mask,
                                                iq_corr_pkg::GAIN_WR_MASK) : i_gain_register_reg;
    wire  [15:0] qgain_next  = wr_qgain ? merge(q_gain_register_reg, wd, be_mask,
                                                iq_corr_pkg::GAIN_WR_MASK) : q_gain_register_reg;
    wire  [15:0] outlat_next = wr_outlat ? merge(out_lat_reg, wd, be_mask,
                                                 iq_corr_pkg::OUT_LAT_WR_MASK) : out_lat_reg;

    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready  = !w_held_reg && !bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rdata   = rdata_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (do_write) begin
            w_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= iq_corr_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_hit ? iq_corr_pkg::RESP_OKAY : iq_corr_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Staged registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            i_gain_register_reg           <= iq_corr_pkg::RST_GAIN;
            q_gain_register_reg           <= iq_corr_pkg::RST_GAIN;
            out_lat_reg                   <= iq_corr_pkg::RST_OUT_LAT;
            phase_correction_register_reg <= iq_corr_pkg::RST_PHASE;
            autosync_en_reg               <= 1'b0;
        end else begin
            i_gain_register_reg           <= igain_next;
            q_gain_register_reg           <= qgain_next;
            out_lat_reg                   <= outlat_next;
            phase_correction_register_reg <= phase_next;
            if (wr_sync && w_strb_reg[0]) begin
                autosync_en_reg <= wd[iq_corr_pkg::SYNC_EN_BIT];
            end
        end
    end

    // Active settings, loaded together on a sync event
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            act_i_gain_reg <= iq_corr_pkg::RST_GAIN[GW-1:0];
            act_q_gain_reg <= iq_corr_pkg::RST_GAIN[GW-1:0];
            act_phase_reg  <= iq_corr_pkg::RST_PHASE[PW-1:0];
            sync_count_reg <= '0;
        end else if (sync_evt) begin
            act_i_gain_reg <= igain_next[GW-1:0];
            act_q_gain_reg <= qgain_next[GW-1:0];
            act_phase_reg  <= phase_next[PW-1:0];
            sync_count_reg <= sync_count_reg + 8'h01;
        end
    end

    // External sync pin
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_sync_meta_reg <= 1'b0;
            ext_sync_sync_reg <= 1'b0;
            ext_sync_prev_reg <= 1'b0;
        end else begin
            ext_sync_meta_reg <= ext_sync;
            ext_sync_sync_reg <= ext_sync_meta_reg;
            ext_sync_prev_reg <= ext_sync_sync_reg;
        end
    end

    // Read path
    wire  [7:0]  ra        = s_axi_araddr;
    wire  [LVL_W-1:0] fifo_level;
    wire         rd_hit    = (ra == iq_corr_pkg::ADDR_I_GAIN) || (ra == iq_corr_pkg::ADDR_Q_GAIN) ||
                             (ra == iq_corr_pkg::ADDR_RSVD_0E) || (ra == iq_corr_pkg::ADDR_OUT_LAT) ||
                             (ra == iq_corr_pkg::ADDR_PHASE) || (ra == iq_corr_pkg::ADDR_SYNC_CTRL) ||
                             (ra == iq_corr_pkg::ADDR_ACT_STATUS) || (ra == iq_corr_pkg::ADDR_ACT_GAINS);
    wire  [31:0] status_w  = 32'({sync_count_reg, fifo_level, act_phase_reg});
    wire  [31:0] gains_w   = {5'h00, act_q_gain_reg, 5'h00, act_i_gain_reg};
    wire  [31:0] rd_mux    =
        (ra == iq_corr_pkg::ADDR_I_GAIN)     ? {16'h0000, i_gain_register_reg} :
        (ra == iq_corr_pkg::ADDR_Q_GAIN)     ? {16'h0000, q_gain_register_reg} :
        (ra == iq_corr_pkg::ADDR_RSVD_0E)    ? {16'h0000, iq_corr_pkg::RST_RSVD_0E} :
        (ra == iq_corr_pkg::ADDR_OUT_LAT)    ? {16'h0000, out_lat_reg} :
        (ra == iq_corr_pkg::ADDR_PHASE)      ? {16'h0000, phase_correction_register_reg} :
        (ra == iq_corr_pkg::ADDR_SYNC_CTRL)  ? {31'h00000000, autosync_en_reg} :
        (ra == iq_corr_pkg::ADDR_ACT_STATUS) ? status_w :
        (ra == iq_corr_pkg::ADDR_ACT_GAINS)  ? gains_w : 32'h00000000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rresp_reg  <= iq_corr_pkg::RESP_OKAY;
            rdata_reg  <= '0;
        end else if (ar_take) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= rd_hit ? iq_corr_pkg::RESP_OKAY : iq_corr_pkg::RESP_SLVERR;
            rdata_reg  <= rd_mux;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // Correction arithmetic
    wire signed [SAMPLE_W-1:0] a_s     = in_a;
    wire signed [SAMPLE_W-1:0] b_s     = in_b;
    wire signed [GW:0]         gi_s    = {1'b0, act_i_gain_reg};
    wire signed [GW:0]         gq_s    = {1'b0, act_q_gain_reg};
    wire signed [PW-1:0]       ph_s    = act_phase_reg;
    wire signed [PROD_W-1:0]   a_gain  = a_s * gi_s;
    wire signed [PROD_W-1:0]   b_gain  = b_s * gq_s;
    wire signed [SAMPLE_W+PW-1:0] ph_prod = b_s * ph_s;
    wire signed [PROD_W-1:0]   a_gsh   = a_gain >>> iq_corr_pkg::GAIN_FRAC;
    wire signed [PROD_W-1:0]   b_gsh   = b_gain >>> iq_corr_pkg::GAIN_FRAC;
    wire signed [SAMPLE_W+PW-1:0] ph_sh = ph_prod >>> iq_corr_pkg::PHASE_FRAC;
    wire signed [SUM_W-1:0]    a_sum   = SUM_W'(a_gsh) + SUM_W'(ph_sh);
    wire signed [SUM_W-1:0]    b_sum   = SUM_W'(b_gsh);

    // Saturate a wide sum to the sample width
    function automatic logic [SAMPLE_W-1:0] sat(input logic signed [SUM_W-1:0] v);
        logic signed [SUM_W-1:0] hi;
        logic signed [SUM_W-1:0] lo;
        hi = SUM_W'({1'b0, {(SAMPLE_W-1){1'b1}}});
        lo = -hi - SUM_W'(1);
        if (v > hi) begin
            sat = {1'b0, {(SAMPLE_W-1){1'b1}}};
        end else if (v < lo) begin
            sat = {1'b1, {(SAMPLE_W-1){1'b0}}};
        end else begin
            sat = v[SAMPLE_W-1:0];
        end
    endfunction

    // Pipeline advances only when the output buffer has room
    wire                  fifo_in_ready;
    wire                  advance = fifo_in_ready;
    localparam int        DLY_SEL_W = iq_corr_pkg::DLY_W;
    wire [DLY_SEL_W-1:0]  dly_sel;
    assign dly_sel  = out_lat_reg[iq_corr_pkg::DLY_LSB +: DLY_SEL_W];
    assign in_ready = advance;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            v0_reg <= 1'b0;
            a0_reg <= '0;
            b0_reg <= '0;
        end else if (advance) begin
            v0_reg <= in_valid;
            a0_reg <= sat(a_sum);
            b0_reg <= sat(b_sum);
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < iq_corr_pkg::MAX_DLY; gi++) begin : g_dly
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    v_dly_reg[gi] <= 1'b0;
                    a_dly_reg[gi] <= '0;
                    b_dly_reg[gi] <= '0;
                end else if (advance) begin
                    v_dly_reg[gi] <= (gi == 0) ? v0_reg : v_dly_reg[(gi == 0) ? 0 : gi - 1];
                    a_dly_reg[gi] <= (gi == 0) ? a0_reg : a_dly_reg[(gi == 0) ? 0 : gi - 1];
                    b_dly_reg[gi] <= (gi == 0) ? b0_reg : b_dly_reg[(gi == 0) ? 0 : gi - 1];
                end
            end
        end
    endgenerate

    // One tap serves both channels
    wire                  tap_v = (dly_sel == 2'd0) ? v0_reg : v_dly_reg[dly_sel - 2'd1];
    wire [SAMPLE_W-1:0]   tap_a = (dly_sel == 2'd0) ? a0_reg : a_dly_reg[dly_sel - 2'd1];
    wire [SAMPLE_W-1:0]   tap_b = (dly_sel == 2'd0) ? b0_reg : b_dly_reg[dly_sel - 2'd1];
    wire [2*SAMPLE_W-1:0] fifo_out;

    sample_fifo #(
        .WIDTH (2 * SAMPLE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_valid  (tap_v),
        .in_ready  (fifo_in_ready),
        .in_data   ({tap_a, tap_b}),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (fifo_out),
        .level     (fifo_level)
    );

    assign out_a = fifo_out[2*SAMPLE_W-1:SAMPLE_W];
    assign out_b = fifo_out[SAMPLE_W-1:0];
endmodule

/* File: iq_phase_corr_output_delay_chk.sv */
`timescale 1ns/10ps
module iq_phase_corr_output_delay_chk #(
    parameter int SAMPLE_W = 16
) (
    input wire logic                aclk,
    input wire logic                aresetn,
    input wire logic                s_axi_awvalid,
    input wire logic                s_axi_awready,
    input wire logic                s_axi_wvalid,
    input wire logic                s_axi_wready,
    input wire logic                s_axi_bvalid,
    input wire logic [7:0]          s_axi_araddr,
    input wire logic                s_axi_arvalid,
    input wire logic                s_axi_arready,
    input wire logic [31:0]         s_axi_rdata,
    input wire logic                s_axi_rvalid,
    input wire logic                out_valid,
    input wire logic                out_ready,
    input wire logic [SAMPLE_W-1:0] out_a,
    input wire logic [SAMPLE_W-1:0] out_b
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer missing");
    property p_wr_answer; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid; endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write answer missing");
    property p_w_refused; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_w_refused: assert property (p_w_refused) else $error("write taken while answer pending");
    property p_r_refused; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_r_refused: assert property (p_r_refused) else $error("read taken while answer pending");
    property p_out_hold; out_valid && !out_ready |=> out_valid && $stable(out_a) && $stable(out_b); endproperty
    a_out_hold: assert property (p_out_hold) else $error("stalled sample changed");
    property p_rsvd_read;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == iq_corr_pkg::ADDR_RSVD_0E |=> s_axi_rdata[15:0] == 16'h0400;
    endproperty
    a_rsvd_read: assert property (p_rsvd_read) else $error("reserved register changed");
    property p_lat_read;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == iq_corr_pkg::ADDR_OUT_LAT |=> s_axi_rdata[13:0] == 14'h0400;
    endproperty
    a_lat_read: assert property (p_lat_read) else $error("reserved delay bits changed");
    property p_phase_read;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == iq_corr_pkg::ADDR_PHASE |=> s_axi_rdata[15:14] == 2'b00;
    endproperty
    a_phase_read: assert property (p_phase_read) else $error("phase top bits not zero");
    c_write: cover property (s_axi_bvalid);
    c_read: cover property (s_axi_rvalid);
    c_stall: cover property (out_valid && !out_ready);
endmodule

/* File: iq_phase_corr_output_delay_test.sv */
`timescale 1ns/10ps
module iq_phase_corr_output_delay_test;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        ext_sync, in_valid, out_ready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, in_ready, out_valid;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [2:0]  s_axi_awprot, s_axi_arprot;
    logic [3:0]  s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] in_a, in_b, out_a, out_b, oa, ob;
    int          miscompares, checks_done, lat;
    iq_phase_corr_output_delay i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .ext_sync, .in_valid, .in_ready, .in_a, .in_b, .out_valid, .out_ready, .out_a, .out_b);
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        cmp("write response", 32'h0, {30'h0, s_axi_bresp});
    endtask
    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        cmp(what, e, s_axi_rdata & m);
        cmp("response", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask
    // One sample through; output left stalled two cycles before popping
    task automatic send(input logic [15:0] a, input logic [15:0] b);
        lat = 0;
        in_a <= a;
        in_b <= b;
        in_valid <= 1'b1;
        @(posedge aclk);
        in_valid <= 1'b0;
        cmp("input ready", 32'h1, {31'h0, in_ready});
        while (out_valid !== 1'b1) begin
            @(posedge aclk);
            lat++;
        end
        oa = out_a;
        ob = out_b;
        repeat (2) @(posedge aclk);
        out_ready <= 1'b1;
        @(posedge aclk);
        out_ready <= 1'b0;
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    initial begin
        #50000;
        miscompares++;
        give_verdict;
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, ext_sync, in_valid, out_ready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata, in_a, in_b} = '0;
        {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
        miscompares = 0;
        checks_done = 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd("i gain", iq_corr_pkg::ADDR_I_GAIN, 32'hffff, 32'h0400, 2'h0);
        rd("q gain", iq_corr_pkg::ADDR_Q_GAIN, 32'hffff, 32'h0400, 2'h0);
        rd("delay", iq_corr_pkg::ADDR_OUT_LAT, 32'hffff, 32'h0400, 2'h0);
        rd("phase", iq_corr_pkg::ADDR_PHASE, 32'hffff, 32'h0000, 2'h0);
        rd("unmapped", 8'h44, 32'hffffffff, 32'h0, 2'h2);
        $display("test reset values done");
        wr(iq_corr_pkg::ADDR_RSVD_0E, 32'hffff);
        wr(iq_corr_pkg::ADDR_OUT_LAT, 32'hffff);
        rd("reserved", iq_corr_pkg::ADDR_RSVD_0E, 32'hffff, 32'h0400, 2'h0);
        rd("delay bits", iq_corr_pkg::ADDR_OUT_LAT, 32'hffff, 32'hc400, 2'h0);
        $display("test reserved bits done");
        for (int d = 0; d < 4; d++) begin
            wr(iq_corr_pkg::ADDR_OUT_LAT, {16'h0, d[1:0], 14'h0400});
            send(16'h1234, 16'h8567);
            cmp("latency", 32'(2 + d), 32'(lat));
            cmp("out pair", 32'h12348567, {oa, ob});
        end
        $display("test output delay done");
        wr(iq_corr_pkg::ADDR_I_GAIN, 32'h0200);
        wr(iq_corr_pkg::ADDR_Q_GAIN, 32'h0300);
        wr(iq_corr_pkg::ADDR_PHASE, 32'h3400);
        rd("active gains", iq_corr_pkg::ADDR_ACT_GAINS, 32'h07ff07ff, 32'h04000400, 2'h0);
        rd("active phase", iq_corr_pkg::ADDR_ACT_STATUS, 32'h0fff, 32'h0, 2'h0);
        send(16'h1000, 16'h0800);
        cmp("staged only", 32'h10000800, {oa, ob});
        ext_sync <= 1'b1;
        repeat (4) @(posedge aclk);
        ext_sync <= 1'b0;
        repeat (4) @(posedge aclk);
        rd("synced gains", iq_corr_pkg::ADDR_ACT_GAINS, 32'h07ff07ff, 32'h03000200, 2'h0);
        send(16'h1000, 16'h0800);
        cmp("corrected", 32'h0a000600, {oa, ob});
        $display("test external sync done");
        wr(iq_corr_pkg::ADDR_SYNC_CTRL, 32'h1);
        wr(iq_corr_pkg::ADDR_I_GAIN, 32'h0100);
        wr(iq_corr_pkg::ADDR_Q_GAIN, 32'h0200);
        rd("gains held", iq_corr_pkg::ADDR_ACT_GAINS, 32'h07ff07ff, 32'h03000200, 2'h0);
        wr(iq_corr_pkg::ADDR_PHASE, 32'h3c00);
        rd("auto gains", iq_corr_pkg::ADDR_ACT_GAINS, 32'h07ff07ff, 32'h02000100, 2'h0);
        rd("auto phase", iq_corr_pkg::ADDR_ACT_STATUS, 32'h0fff, 32'h0c00, 2'h0);
        send(16'h1000, 16'h0800);
        cmp("negative phase", 32'h02000400, {oa, ob});
        wr(iq_corr_pkg::ADDR_I_GAIN, 32'h0300);
        rd("gains kept", iq_corr_pkg::ADDR_ACT_GAINS, 32'h07ff07ff, 32'h02000100, 2'h0);
        wr(iq_corr_pkg::ADDR_SYNC_CTRL, 32'h3);
        rd("manual sync", iq_corr_pkg::ADDR_ACT_GAINS, 32'h07ff07ff, 32'h02000300, 2'h0);
        $display("test automatic sync done");
        give_verdict;
    end
endmodule
bind iq_phase_corr_output_delay iq_phase_corr_output_delay_chk #(.SAMPLE_W(SAMPLE_W)) i_chk (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .out_valid, .out_ready, .out_a, .out_b);

/* File: sample_fifo.sv */
`timescale 1ns/10ps
module sample_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             in_valid,
    output      logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output      logic             out_valid,
    input  wire logic             out_ready,
    output      logic [WIDTH-1:0] out_data,
    output      logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_reg[rd_ptr_reg];
    assign level     = count_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end
endmodule
